// ==== rtl/phys_request_filter_high.sv ====
// Purpose: Upper-node physical request filter with set/clear register access
// Assumes: One 25 MHz clock; request inputs come from logic on that clock
// Notes:   Decision appears one cycle after the request strobe
`default_nettype none

module phys_request_filter_high
  import phys_filter_pkg::*;
(
  input  wire logic                 CLK_SYS_I,
  input  wire logic                 RST_N_I,
  // Bus reset pin from the far side, asynchronous to the clock
  input  wire logic                 HOST_BUS_RESET_PIN_N_I,
  // Register port
  input  wire logic [ADDR_W-1:0]    ADDR_I,
  input  wire logic [DATA_W-1:0]    WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output logic      [DATA_W-1:0]    RDATA_O,
  // Incoming request to classify
  input  wire logic                 REQ_VALID_I,
  input  wire logic [NODE_ID_W-1:0] REQ_SRC_NODE_I,
  input  wire logic                 REQ_SRC_LOCAL_I,
  input  wire logic                 REQ_PHYS_DEST_I,
  input  wire logic                 REQ_ASYNC_PASS_I,
  // Routing decision
  output logic                      ROUTE_VALID_O,
  output logic                      ROUTE_PHYS_O,
  output logic                      ROUTE_ASYNC_O,
  output logic                      ROUTE_NO_ACK_O,
  output logic                      ROUTE_DEFER_O,
  output logic      [DATA_W-1:0]    FILTER_O
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [DATA_W-1:0] filter;
    logic [DATA_W-1:0] rdata;
    logic              pin_meta;
    logic              pin_sync;
    logic              valid;
    logic              phys;
    logic              async_ctx;
    logic              no_ack;
    logic              defer;
  } state_t;

  localparam state_t STATE_RESET = '{
    filter:    FILTER_RESET,
    rdata:     UNMAPPED_READ,
    pin_meta:  1'b1,
    pin_sync:  1'b1,
    valid:     1'b0,
    phys:      1'b0,
    async_ctx: 1'b0,
    no_ack:    1'b0,
    defer:     1'b0
  };

  state_t state_reg;
  state_t state_next;

  logic       set_hit;
  logic       clear_hit;
  logic [4:0] node_index;
  logic       node_upper;
  logic       node_enabled;

  assign set_hit    = WR_I && (ADDR_I == FILTER_SET_ADDR);
  assign clear_hit  = WR_I && (ADDR_I == FILTER_CLEAR_ADDR);
  assign node_upper = (REQ_SRC_NODE_I >= UPPER_NODE_BASE) && (REQ_SRC_NODE_I != BROADCAST_NODE);
  assign node_index = REQ_SRC_NODE_I[4:0];
  // Index 31 would be the all-buses bit; node 63 is excluded above
  assign node_enabled = node_upper && state_reg.filter[node_index];

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;

    // Pin passes two flops before anything looks at it
    state_next.pin_meta = HOST_BUS_RESET_PIN_N_I;
    state_next.pin_sync = state_reg.pin_meta;

    // Only ones written take effect at either address
    if (set_hit)
    begin
      state_next.filter = state_reg.filter | WDATA_I;
    end
    else if (clear_hit)
    begin
      state_next.filter = state_reg.filter & ~WDATA_I;
    end

    // Bus reset pin clears node bits but keeps the all-buses bit
    if (!state_reg.pin_sync)
    begin
      state_next.filter = state_next.filter & PIN_RESET_KEEP_MASK;
    end

    // Both addresses read back the live contents
    if (RD_I && ((ADDR_I == FILTER_SET_ADDR) || (ADDR_I == FILTER_CLEAR_ADDR)))
    begin
      state_next.rdata = state_reg.filter;
    end
    else
    begin
      state_next.rdata = UNMAPPED_READ;
    end

    // Decision defaults to nothing
    state_next.valid     = REQ_VALID_I;
    state_next.phys      = 1'b0;
    state_next.async_ctx = 1'b0;
    state_next.no_ack    = 1'b0;
    state_next.defer     = 1'b0;

    if (REQ_VALID_I)
    begin
      if (!REQ_SRC_LOCAL_I)
      begin
        // Remote sources skip the per-node comparison
        if (state_reg.filter[ALL_BUSES_BIT])
        begin
          state_next.phys      = REQ_PHYS_DEST_I;
          state_next.async_ctx = !REQ_PHYS_DEST_I;
        end
        else
        begin
          state_next.no_ack = 1'b1;
        end
      end
      else if (!REQ_ASYNC_PASS_I)
      begin
        // Rejected upstream; this filter is never consulted
        state_next.no_ack = 1'b1;
      end
      else if (!REQ_PHYS_DEST_I)
      begin
        state_next.async_ctx = 1'b1;
      end
      else if (!REQ_SRC_NODE_I[5])
      begin
        // Lower nodes belong to the companion filter
        state_next.defer = 1'b1;
      end
      else if (node_enabled)
      begin
        state_next.phys = 1'b1;
      end
      else
      begin
        state_next.async_ctx = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign RDATA_O        = state_reg.rdata;
  assign ROUTE_VALID_O  = state_reg.valid;
  assign ROUTE_PHYS_O   = state_reg.phys;
  assign ROUTE_ASYNC_O  = state_reg.async_ctx;
  assign ROUTE_NO_ACK_O = state_reg.no_ack;
  assign ROUTE_DEFER_O  = state_reg.defer;
  assign FILTER_O       = state_reg.filter;

endmodule : phys_request_filter_high

`default_nettype wire

// ==== rtl/phys_filter_pkg.sv ====
// Purpose: Constants for the upper physical request filter
// Assumes: 32-bit register port, byte addresses as printed
// Notes:   Shared by the design and the bench
//
// What this block does
// - Bit n (0..30) set routes physical requests from local node 32+n physically.
// - Bit clear: physical-bound request from that node goes to async receive context.
// - Local-bus requests consult the filter only after passing the asynchronous request filter.
// - Per-node comparison applies only to sources on the local bus.
// - Packets from remote buses get no acknowledge unless bit 31 is set.
// - Bit 31 set: every request from remote-bus nodes is accepted.
// - Bus reset pin leaves bit 31 alone; bits 30..0 clear on it.
// - Writes at set address set bits, clear address clears; reads show contents.
// - All 32 bits are zero after reset.
`default_nettype none

package phys_filter_pkg;

  // ==========================================================
  // Register map
  localparam int          ADDR_W              = 12;
  localparam logic [11:0] FILTER_SET_ADDR     = 12'h110;
  localparam logic [11:0] FILTER_CLEAR_ADDR   = 12'h114;

  // ==========================================================
  // Field layout and reset values
  localparam int          DATA_W              = 32;
  localparam int          ALL_BUSES_BIT       = 31;
  localparam int          NODE_BITS           = 31;
  localparam logic [31:0] FILTER_RESET        = 32'h0000_0000;
  localparam logic [31:0] PIN_RESET_KEEP_MASK = 32'h8000_0000;
  localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;

  // ==========================================================
  // Node numbering
  localparam int          NODE_ID_W           = 6;
  localparam logic [5:0]  UPPER_NODE_BASE     = 6'h20;
  localparam logic [5:0]  BROADCAST_NODE      = 6'h3F;

  // ==========================================================
  // Timing
  localparam int          SYNC_STAGES         = 2;
  localparam int          DECISION_LATENCY    = 1;

endpackage : phys_filter_pkg

`default_nettype wire

// ==== tb/phys_filter_checker.sv ====
// Purpose: Port assertions for the upper request filter
// Assumes: One clock, reset active low
// Notes:   Bound to the design from tb_top
`default_nettype none
module phys_filter_checker
  import phys_filter_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        HOST_BUS_RESET_PIN_N_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        REQ_VALID_I,
  input wire logic [5:0]  REQ_SRC_NODE_I,
  input wire logic        REQ_SRC_LOCAL_I,
  input wire logic        REQ_PHYS_DEST_I,
  input wire logic        REQ_ASYNC_PASS_I,
  input wire logic        ROUTE_PHYS_O,
  input wire logic        ROUTE_ASYNC_O,
  input wire logic        ROUTE_NO_ACK_O,
  input wire logic [31:0] FILTER_O
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Request classes; local node 63 never routes physically
  wire logic        ph  = HOST_BUS_RESET_PIN_N_I;
  wire logic        lq  = REQ_VALID_I && REQ_SRC_LOCAL_I && REQ_ASYNC_PASS_I && REQ_PHYS_DEST_I;
  wire logic        lf  = REQ_VALID_I && REQ_SRC_LOCAL_I && !REQ_ASYNC_PASS_I;
  wire logic        rq  = REQ_VALID_I && !REQ_SRC_LOCAL_I;
  wire logic        up  = REQ_SRC_NODE_I[5] && REQ_SRC_NODE_I != BROADCAST_NODE;
  wire logic        hit = FILTER_O[REQ_SRC_NODE_I[4:0]];
  wire logic        ws  = WR_I && ADDR_I == FILTER_SET_ADDR;
  wire logic        wc  = WR_I && ADDR_I == FILTER_CLEAR_ADDR;
  logic      [31:0] mask_reg;
  logic      [31:0] hold_reg;
  always_ff @(posedge CLK_SYS_I)
  begin
    mask_reg <= ~WDATA_I;
    hold_reg <= FILTER_O & ~WDATA_I;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  a_node_phys: assert property (lq && up && hit |=> ROUTE_PHYS_O)
    else $error("no phys route");
  a_async_fallback: assert property (lq && up && !hit |=> ROUTE_ASYNC_O)
    else $error("no async route");
  a_pass_first: assert property (lf |=> ROUTE_NO_ACK_O)
    else $error("unfiltered node taken");
  a_remote_noack: assert property (rq && !FILTER_O[31] |=> ROUTE_NO_ACK_O)
    else $error("remote acked");
  a_remote_accept: assert property (rq && FILTER_O[31] |=> ROUTE_PHYS_O || ROUTE_ASYNC_O)
    else $error("remote refused");
  a_pin_clear: assert property (!ph [*4] |-> FILTER_O[30:0] == 31'h0)
    else $error("pin left node bits");
  a_set_bits: assert property (ph [*3] ##0 ws |=> (FILTER_O | mask_reg) == 32'hFFFFFFFF)
    else $error("set failed");
  a_clear_bits: assert property (wc |=> (FILTER_O & ~mask_reg) == 32'h0)
    else $error("clear failed");
  a_zero_keep: assert property (ph [*3] ##0 WR_I |=> (FILTER_O & mask_reg) == hold_reg)
    else $error("zero bit changed");
endmodule : phys_filter_checker
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Directed bench for the upper request filter
// Assumes: All inputs driven on the rising edge
// Notes:   Checker bound at the foot
`default_nettype none
module tb_top
  import phys_filter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, wr = 1'b0, rd = 1'b0, rv = 1'b0;
  logic [2:0]  flg = 3'h0;
  logic [5:0]  node = 6'h00;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0;
  wire  [31:0] rdata, filt;
  wire  [4:0]  route;
  int          num_errors = 0, compares = 0, cyc = 0;
  localparam logic [4:0] PH = 5'h18, AS = 5'h14, NA = 5'h12, DF = 5'h11;
  always #20 clk = ~clk;
  phys_request_filter_high dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .HOST_BUS_RESET_PIN_N_I(pin_n), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .REQ_VALID_I(rv), .REQ_SRC_NODE_I(node), .REQ_SRC_LOCAL_I(flg[2]),
    .REQ_ASYNC_PASS_I(flg[1]), .REQ_PHYS_DEST_I(flg[0]), .ROUTE_VALID_O(route[4]),
    .ROUTE_PHYS_O(route[3]), .ROUTE_ASYNC_O(route[2]), .ROUTE_NO_ACK_O(route[1]),
    .ROUTE_DEFER_O(route[0]), .FILTER_O(filt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
    // Read data stands for one cycle only, then drops back to zero
    @(posedge clk) #1 chk(rdata, UNMAPPED_READ);
  endtask : rd_chk
  // Flags are local, passed async filter, physical destination
  task automatic req(input logic [5:0] n, input logic [2:0] f, input logic [4:0] e);
    @(posedge clk);
    node <= n;
    flg  <= f;
    rv   <= 1'b1;
    @(posedge clk);
    rv   <= 1'b0;
    #1 chk(32'(route), 32'(e));
  endtask : req
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(FILTER_SET_ADDR, FILTER_RESET);
    wr_reg(FILTER_SET_ADDR, 32'h4000_0003);
    wr_reg(FILTER_SET_ADDR, 32'h0000_0004);
    rd_chk(FILTER_CLEAR_ADDR, 32'h4000_0007);
    for (int n = 32; n < 64; n++)
      req(6'(n), 3'h7, (n inside {32, 33, 34, 62}) ? PH : AS);
    req(6'h05, 3'h7, DF);
    req(6'h21, 3'h5, NA);
    req(6'h21, 3'h6, AS);
    req(6'h21, 3'h1, NA);
    wr_reg(FILTER_SET_ADDR, 32'h8000_0000);
    req(6'h23, 3'h1, PH);
    req(6'h23, 3'h0, AS);
    wr_reg(FILTER_CLEAR_ADDR, 32'h0000_0001);
    wr_reg(12'h118, 32'hFFFF_FFFF);
    rd_chk(12'h118, 32'h0000_0000);
    rd_chk(FILTER_SET_ADDR, 32'hC000_0006);
    @(posedge clk) pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(FILTER_SET_ADDR, PIN_RESET_KEEP_MASK);
    @(posedge clk) pin_n <= 1'b1;
    conclude();
  end
endmodule : tb_top
bind phys_request_filter_high phys_filter_checker chk_u (.*);
`default_nettype wire
